// ==== bus_cycle_model.sv ====
module bus_cycle_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [2:0] kind,
    input wire logic [1:0] size,
    input wire logic [31:0] data,
    input wire logic address_space_id_ok,
    input wire logic a_hit,
    output logic bus_valid,
    output logic bus_is_dma,
    output logic bus_is_fetch,
    output logic bus_is_write,
    output logic [1:0] bus_size,
    output logic [31:0] bus_data,
    output logic addr_match_b,
    output logic address_space_id_match_b,
    output logic hit_cpu_a,
    output logic hit_dma_a
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {bus_valid, bus_is_dma, bus_is_fetch, bus_is_write, bus_size} = '0;
        {bus_data, addr_match_b, address_space_id_match_b, hit_cpu_a, hit_dma_a} = '0;
    end
    // One bus cycle per request; between cycles the data lines keep changing, so nothing stale can match.
    always @(posedge clk) begin
        bus_valid <= go;
        {bus_is_dma, bus_is_fetch, bus_is_write} <= go ? kind : ~kind;
        bus_size <= go ? size : ~size;
        bus_data <= go ? data : ~bus_data;
        addr_match_b <= go;
        address_space_id_match_b <= go & address_space_id_ok;
        hit_cpu_a <= go & a_hit & ~kind[2];
        hit_dma_a <= go & a_hit & kind[2];
    end
endmodule

// ==== chan_b_compare.sv ====
module chan_b_compare
    import ubc_b_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] cycle_sel,
    input wire logic [31:0] data_value,
    input wire logic [31:0] data_mask,
    input wire logic data_compare_enable_b,
    input wire logic space_id_ignore_b,
    input wire logic bus_valid,
    input wire logic bus_is_dma,
    input wire logic bus_is_fetch,
    input wire logic bus_is_write,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_data,
    input wire logic addr_match_b,
    input wire logic address_space_id_match_b,
    output logic hit_cpu,
    output logic hit_dma
);
    // A two-bit select that allows the first option, the second, or both.
    function automatic logic either_ok(input logic [1:0] sel, input logic opt0, input logic opt1);
        either_ok = (sel[0] & opt0) | (sel[1] & opt1);
    endfunction

    logic [3:0] lane_ok;
    logic master_ok, kind_ok, dir_ok, size_ok, data_ok, cond;

    // Per-lane masked data compare; a mask bit of 1 drops that bit.
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_lane
            assign lane_ok[i] = &(data_mask[8*i +: 8] | ~(data_value[8*i +: 8] ^ bus_data[8*i +: 8]));
        end
    endgenerate

    // Byte and word cycles carry data on the low half only.
    always_comb begin
        if (bus_size == SIZE_BYTE || bus_size == SIZE_WORD) begin
            data_ok = lane_ok[0] & lane_ok[1];
        end else begin
            data_ok = &lane_ok;
        end
    end

    assign master_ok = cycle_sel[SEL_MASTER] ? !bus_is_dma : (cycle_sel[SEL_MASTER+1] & bus_is_dma);
    assign kind_ok = either_ok(cycle_sel[SEL_KIND +: 2], bus_is_fetch, !bus_is_fetch);
    assign dir_ok = either_ok(cycle_sel[SEL_DIR +: 2], !bus_is_write, bus_is_write);
    assign size_ok = (cycle_sel[SEL_SIZE +: 2] == SIZE_ANY) || (cycle_sel[SEL_SIZE +: 2] == bus_size);
    assign cond = bus_valid & master_ok & kind_ok & dir_ok & size_ok & addr_match_b
                & (space_id_ignore_b | address_space_id_match_b) & (!data_compare_enable_b | data_ok);

    // The hit is registered so that it lines up with the channel A result.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hit_cpu <= 1'b0;
            hit_dma <= 1'b0;
        end else if (ce) begin
            hit_cpu <= cond & !bus_is_dma;
            hit_dma <= cond & bus_is_dma;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_master_off: assert property (ce && cycle_sel[7:6] == 2'b00 |=> !hit_cpu && !hit_dma)
        else $error("hit with master compare off");
    a_kind_off: assert property (ce && cycle_sel[5:4] == 2'b00 |=> !hit_cpu && !hit_dma)
        else $error("hit with access kind compare off");
    a_data_gate: assert property (ce && data_compare_enable_b && !data_ok |=> !hit_cpu && !hit_dma)
        else $error("hit with data mismatch");
endmodule

// ==== ubc_b_pkg.sv ====
package ubc_b_pkg;
    // Register offsets on the plain register port.
    localparam logic [7:0] OFS_DATA_VALUE = 8'h00;
    localparam logic [7:0] OFS_DATA_MASK = 8'h04;
    localparam logic [7:0] OFS_CYCLE_SEL = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h14;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h18;

    // Values after reset.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_CYCLE = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [2:0] RST_INT = 3'h0;

    // Writable setting bits of the control register, match flags excluded.
    localparam logic [31:0] CTRL_WR_MASK = 32'h0030_0cc9;

    // Control register bit positions.
    localparam int CTRL_IGN_A = 21;
    localparam int CTRL_IGN_B = 20;
    localparam int CTRL_FLAG_LO = 12;
    localparam int CTRL_TRACE = 11;
    localparam int CTRL_AFTER_A = 10;
    localparam int CTRL_DBE = 7;
    localparam int CTRL_AFTER_B = 6;
    localparam int CTRL_SEQ = 3;
    localparam int CTRL_COUNT_BREAK_ENABLE = 0;

    // Match flag positions inside the four-bit flag group (bits 15 to 12).
    localparam int FLAG_CPU_A = 3;
    localparam int FLAG_CPU_B = 2;
    localparam int FLAG_DMA_A = 1;
    localparam int FLAG_DMA_B = 0;

    // Cycle select field positions (low bit of each two-bit field).
    localparam int SEL_MASTER = 6;
    localparam int SEL_KIND = 4;
    localparam int SEL_DIR = 2;
    localparam int SEL_SIZE = 0;

    // Operand size codes, shared by the register field and the bus.
    localparam logic [1:0] SIZE_ANY = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LONG = 2'h3;

    // Interrupt status bits.
    localparam int INT_BREAK = 0;
    localparam int INT_HIT_A = 1;
    localparam int INT_HIT_B = 2;

    typedef enum logic [1:0] {
        CHAIN_IDLE = 2'b01,
        CHAIN_ARMED = 2'b10
    } chain_state_t;
endpackage

// ==== user_break_b.sv ====
// Overview of operation
// - Data value register, 32 bits, reset zero.
// - Mask bit 1 drops that data bit.
// - Cycle select: 16 bits, upper byte zero.
// - Master field: off, CPU, or DMA.
// - Kind field: off, fetch, data, either.
// - Direction field: off, read, write, either.
// - Size field: any, byte, word, long.
// - Control resets zero; bits 31-22 read zero.
// - Bit 21 skips channel A identifier check.
// - Bit 20 skips channel B identifier check.
// - Bit 3 picks independent or chained channels.
// - Control holds match flags and settings.
// - Match flags stick until written zero.
// - Chained: A first, then B breaks.
// - Count mode: decrement, break at one.
// - Bit 7 adds masked data compare.
//
// Added by the designer: the register addresses and strobed register access.
module user_break_b
    import ubc_b_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic bus_valid,
    input wire logic bus_is_dma,
    input wire logic bus_is_fetch,
    input wire logic bus_is_write,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_data,
    input wire logic addr_match_b,
    input wire logic address_space_id_match_b,
    input wire logic hit_cpu_a,
    input wire logic hit_dma_a,
    input wire logic count_is_one,
    output logic count_decrement,
    output logic break_req,
    output logic space_id_ignore_a,
    output logic space_id_ignore_b,
    output logic branch_trace_enable,
    output logic fetch_break_after_a,
    output logic fetch_break_after_b,
    output logic irq
);
    logic [31:0] data_value, data_mask, settings;
    logic [7:0] cycle_sel;
    logic [3:0] flags, flag_set;
    logic [2:0] int_status, int_enable, int_set;
    logic a_cpu, a_dma, b_cpu, b_dma, hit_a, hit_b;
    logic seq, count_break_enable, a_go, b_go, b_fire, brk_event;
    logic wr_ctrl, next_break;
    chain_state_t chain_state;

    // Channel B comparator on the current bus cycle.
    chan_b_compare u_cmp (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .cycle_sel(cycle_sel),
        .data_value(data_value),
        .data_mask(data_mask),
        .data_compare_enable_b(settings[CTRL_DBE]),
        .space_id_ignore_b(settings[CTRL_IGN_B]),
        .bus_valid(bus_valid),
        .bus_is_dma(bus_is_dma),
        .bus_is_fetch(bus_is_fetch),
        .bus_is_write(bus_is_write),
        .bus_size(bus_size),
        .bus_data(bus_data),
        .addr_match_b(addr_match_b),
        .address_space_id_match_b(address_space_id_match_b),
        .hit_cpu(b_cpu),
        .hit_dma(b_dma)
    );

    // Channel A results are delayed one cycle to meet channel B's.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            a_cpu <= 1'b0;
            a_dma <= 1'b0;
        end else if (ce) begin
            a_cpu <= hit_cpu_a;
            a_dma <= hit_dma_a;
        end
    end

    assign hit_a = a_cpu | a_dma;
    assign hit_b = b_cpu | b_dma;
    assign seq = settings[CTRL_SEQ];
    assign count_break_enable = settings[CTRL_COUNT_BREAK_ENABLE];
    assign wr_ctrl = reg_wr && reg_addr == OFS_CONTROL;

    // Data value and mask registers.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_value <= RST_WORD;
            data_mask <= RST_WORD;
        end else if (ce && reg_wr) begin
            if (reg_addr == OFS_DATA_VALUE) begin
                data_value <= reg_wdata;
            end
            if (reg_addr == OFS_DATA_MASK) begin
                data_mask <= reg_wdata;
            end
        end
    end

    // Cycle select keeps only its low byte; the upper byte has no storage.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cycle_sel <= RST_CYCLE;
        end else if (ce && reg_wr && reg_addr == OFS_CYCLE_SEL) begin
            cycle_sel <= reg_wdata[7:0];
        end
    end

    // Control settings; reserved bits never get stored.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            settings <= RST_WORD;
        end else if (ce && wr_ctrl) begin
            settings <= reg_wdata & CTRL_WR_MASK;
        end
    end

    assign space_id_ignore_a = settings[CTRL_IGN_A];
    assign space_id_ignore_b = settings[CTRL_IGN_B];
    assign branch_trace_enable = settings[CTRL_TRACE];
    assign fetch_break_after_a = settings[CTRL_AFTER_A];
    assign fetch_break_after_b = settings[CTRL_AFTER_B];

    // Match flags: a hit in the cycle of a clearing write still sets.
    assign flag_set = {a_cpu, b_cpu, a_dma, b_dma};
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags <= RST_FLAGS;
        end else if (ce) begin
            if (wr_ctrl) begin
                flags <= (flags & reg_wdata[CTRL_FLAG_LO +: 4]) | flag_set;
            end else begin
                flags <= flags | flag_set;
            end
        end
    end

    assign a_go = hit_a & !seq;
    assign b_go = hit_b & (!seq || chain_state == CHAIN_ARMED);
    assign b_fire = b_go & (!count_break_enable | count_is_one);
    assign brk_event = a_go | b_fire;
    assign next_break = brk_event;

    // Chain sequencer: armed by channel A, released by the channel B break.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            chain_state <= CHAIN_IDLE;
        end else if (ce) begin
            unique case (chain_state)
                CHAIN_IDLE: begin
                    if (seq && hit_a) begin
                        chain_state <= CHAIN_ARMED;
                    end
                end
                CHAIN_ARMED: begin
                    if (!seq || b_fire) begin
                        chain_state <= CHAIN_IDLE;
                    end
                end
                default: begin
                    chain_state <= CHAIN_IDLE;
                end
            endcase
        end
    end

    // Break request and count step, one-cycle pulses.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            break_req <= 1'b0;
            count_decrement <= 1'b0;
        end else if (ce) begin
            break_req <= next_break;
            count_decrement <= b_go & count_break_enable & !count_is_one;
        end
    end

    // Interrupt status: sticky, write-one clear, a new event wins.
    assign int_set = {hit_b, hit_a, brk_event};
    always_ff @(posedge clk) begin
        if (!rstn) begin
            int_status <= RST_INT;
            int_enable <= RST_INT;
        end else if (ce) begin
            if (reg_wr && reg_addr == OFS_INT_CLEAR) begin
                int_status <= (int_status & ~reg_wdata[2:0]) | int_set;
            end else begin
                int_status <= int_status | int_set;
            end
            if (reg_wr && reg_addr == OFS_INT_ENABLE) begin
                int_enable <= reg_wdata[2:0];
            end
        end
    end

    assign irq = |(int_status & int_enable);

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= RST_WORD;
        end else if (ce) begin
            reg_rdata <= RST_WORD;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFS_DATA_VALUE: reg_rdata <= data_value;
                    OFS_DATA_MASK: reg_rdata <= data_mask;
                    OFS_CYCLE_SEL: reg_rdata <= {24'h00_0000, cycle_sel};
                    OFS_CONTROL: reg_rdata <= settings | {16'h0000, flags, 12'h000};
                    OFS_INT_STATUS: reg_rdata <= {29'h0000_0000, int_status};
                    OFS_INT_ENABLE: reg_rdata <= {29'h0000_0000, int_enable};
                    default: reg_rdata <= RST_WORD;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_data_readback: assert property (
        ce && reg_wr && reg_addr == OFS_DATA_VALUE ##1 (ce && !reg_wr)
        ##1 ce && reg_rd && !reg_wr && reg_addr == OFS_DATA_VALUE
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("data value readback wrong");
    a_cycle_upper_zero: assert property (ce && reg_rd && reg_addr == OFS_CYCLE_SEL |=> reg_rdata[31:8] == 24'h00_0000)
        else $error("cycle select upper byte not zero");
    a_ctrl_reserved: assert property (ce && reg_rd && reg_addr == OFS_CONTROL |=> reg_rdata[31:22] == 10'h000)
        else $error("control reserved bits not zero");
    a_ign_a_follow: assert property (ce && wr_ctrl |=> space_id_ignore_a == $past(reg_wdata[CTRL_IGN_A]))
        else $error("channel A identifier mask not taken");
    a_ign_b_follow: assert property (ce && wr_ctrl |=> space_id_ignore_b == $past(reg_wdata[CTRL_IGN_B]))
        else $error("channel B identifier mask not taken");
    a_indep_break: assert property (ce && !seq && hit_a |=> break_req)
        else $error("independent channel A hit gave no break");
    a_flag_sticky: assert property (ce && b_cpu ##1 (ce && !wr_ctrl)[*2] |-> flags[FLAG_CPU_B])
        else $error("channel B CPU flag lost");
    a_flag_clear: assert property (ce && wr_ctrl && !reg_wdata[15] && !a_cpu |=> !flags[FLAG_CPU_A])
        else $error("channel A CPU flag not cleared");
    a_seq_blocks_b: assert property (ce && seq && chain_state == CHAIN_IDLE |=> !break_req)
        else $error("chained break without channel A first");
    a_count_step: assert property (ce && count_break_enable && !seq && hit_b && !hit_a && !count_is_one
        |=> count_decrement && !break_req)
        else $error("count mode did not decrement");

    c_chain_break: cover property (ce && chain_state == CHAIN_ARMED && b_fire ##1 break_req);
    c_count_break: cover property (ce && count_break_enable && hit_b && count_is_one ##1 break_req);
    c_flag_cleared: cover property (flags[FLAG_DMA_B] ##1 !flags[FLAG_DMA_B]);
    c_irq_raised: cover property (!irq ##1 irq);
endmodule

// ==== user_break_b_test.sv ====
module user_break_b_test;
    import ubc_b_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] sel; logic [31:0] ctl, msk, val; logic [2:0] k; logic [1:0] sz;
        logic [31:0] d; logic address_space_id; logic brk;} row_t;
    logic clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0, go = 0, address_space_id_ok = 0, a_hit = 0, count_is_one = 0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, data = '0, rv;
    logic [2:0] kind = '0;
    logic [1:0] size = '0;
    logic bus_valid, bus_is_dma, bus_is_fetch, bus_is_write, addr_match_b, address_space_id_match_b, hit_cpu_a, hit_dma_a;
    logic [1:0] bus_size;
    logic [31:0] bus_data;
    logic count_decrement, break_req, ign_a, ign_b, trace, after_a, after_b, irq;
    int errors = 0, comparisons = 0, cycles = 0, nb, nd;
    row_t rows[23] = '{
        '{8'h55, 0, 0, 0, 3'h2, 2'h1, 0, 1, 1}, '{8'h55, 0, 0, 0, 3'h6, 2'h1, 0, 1, 0},
        '{8'h95, 0, 0, 0, 3'h6, 2'h1, 0, 1, 1}, '{8'hd5, 0, 0, 0, 3'h2, 2'h1, 0, 1, 1},
        '{8'h15, 0, 0, 0, 3'h2, 2'h1, 0, 1, 0}, '{8'h45, 0, 0, 0, 3'h2, 2'h1, 0, 1, 0},
        '{8'h65, 0, 0, 0, 3'h0, 2'h1, 0, 1, 1}, '{8'h65, 0, 0, 0, 3'h2, 2'h1, 0, 1, 0},
        '{8'h75, 0, 0, 0, 3'h2, 2'h1, 0, 1, 1}, '{8'h59, 0, 0, 0, 3'h2, 2'h1, 0, 1, 0},
        '{8'h5d, 0, 0, 0, 3'h3, 2'h1, 0, 1, 1}, '{8'h51, 0, 0, 0, 3'h2, 2'h1, 0, 1, 0},
        '{8'h54, 0, 0, 0, 3'h2, 2'h3, 0, 1, 1}, '{8'h56, 0, 0, 0, 3'h2, 2'h1, 0, 1, 0},
        '{8'h57, 0, 0, 0, 3'h2, 2'h3, 0, 1, 1}, '{8'h55, 0, 0, 0, 3'h2, 2'h1, 0, 0, 0},
        '{8'h55, 32'h0010_0000, 0, 0, 3'h2, 2'h1, 0, 0, 1},
        '{8'h77, 32'h80, 0, 32'h1234_5678, 3'h2, 2'h3, 32'h1234_5678, 1, 1},
        '{8'h77, 32'h80, 0, 32'h1234_5678, 3'h2, 2'h3, 32'h1234_5679, 1, 0},
        '{8'h77, 32'h80, 32'h1, 32'h1234_5678, 3'h2, 2'h3, 32'h1234_5679, 1, 1},
        '{8'h77, 32'h0, 0, 32'h1234_5678, 3'h2, 2'h3, 32'h1234_5679, 1, 1},
        '{8'h77, 32'h80, 32'hffff_0000, 32'h1234_5678, 3'h2, 2'h3, 32'hedcb_5678, 1, 1},
        '{8'h55, 32'h80, 0, 32'h0000_a5a5, 3'h2, 2'h1, 32'h0000_a5a5, 1, 1}};
    user_break_b dut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
        .bus_is_dma(bus_is_dma), .bus_is_fetch(bus_is_fetch), .bus_is_write(bus_is_write),
        .bus_size(bus_size), .bus_data(bus_data), .addr_match_b(addr_match_b), .address_space_id_match_b(address_space_id_match_b),
        .hit_cpu_a(hit_cpu_a), .hit_dma_a(hit_dma_a), .count_is_one(count_is_one),
        .count_decrement(count_decrement), .break_req(break_req), .space_id_ignore_a(ign_a),
        .space_id_ignore_b(ign_b), .branch_trace_enable(trace), .fetch_break_after_a(after_a),
        .fetch_break_after_b(after_b), .irq(irq));
    bus_cycle_model far (.clk(clk), .go(go), .kind(kind), .size(size), .data(data), .address_space_id_ok(address_space_id_ok),
        .a_hit(a_hit), .bus_valid(bus_valid), .bus_is_dma(bus_is_dma), .bus_is_fetch(bus_is_fetch),
        .bus_is_write(bus_is_write), .bus_size(bus_size), .bus_data(bus_data), .addr_match_b(addr_match_b),
        .address_space_id_match_b(address_space_id_match_b), .hit_cpu_a(hit_cpu_a), .hit_dma_a(hit_dma_a));
    // The clock toggles every half period of 25 ns.
    always #25 clk = ~clk;
    // A hang is cut short well beyond the length of the planned tests.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    // Presents one bus cycle and counts break and decrement pulses in the following cycles.
    task automatic cyc(input logic [2:0] k, input logic [1:0] sz, input logic [31:0] d, input logic as,
        input logic ah);
        nb = 0;
        nd = 0;
        @(posedge clk);
        {go, kind, size, data, address_space_id_ok, a_hit} <= {1'b1, k, sz, d, as, ah};
        @(posedge clk);
        go <= 0;
        repeat (6) begin
            @(posedge clk);
            #1 nb += int'(break_req === 1'b1);
            nd += int'(count_decrement === 1'b1);
        end
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1;
        // Register reset values, unmapped place included.
        foreach (rows[i]) begin
            if (i < 8) begin
                rd(8'(i * 4), rv);
                check("reset value", rv, RST_WORD);
            end
        end
        $display("test reset done");
        // Ordinary cases from the table; cycle select written with its upper three bytes zero.
        foreach (rows[i]) begin
            wr(OFS_DATA_VALUE, rows[i].val);
            wr(OFS_DATA_MASK, rows[i].msk);
            wr(OFS_CYCLE_SEL, {24'h0, rows[i].sel});
            wr(OFS_CONTROL, rows[i].ctl);
            cyc(rows[i].k, rows[i].sz, rows[i].d, rows[i].address_space_id, 1'b0);
            check("row break", 32'(nb), 32'(rows[i].brk));
            rd(OFS_CONTROL, rv);
            check("row flags", 32'(rv[15:12]), rows[i].brk ? (rows[i].k[2] ? 1 : 4) : 0);
        end
        $display("test table done");
        // Access kinds of the settings registers.
        wr(OFS_DATA_VALUE, 32'hffff_ffff);
        rd(OFS_DATA_VALUE, rv);
        check("data value", rv, 32'hffff_ffff);
        // A write while the clock enable is low must leave the register alone.
        ce <= 0;
        wr(OFS_DATA_VALUE, 32'h0);
        ce <= 1;
        rd(OFS_DATA_VALUE, rv);
        check("frozen data value", rv, 32'hffff_ffff);
        wr(OFS_CYCLE_SEL, 32'hffff_ffff);
        rd(OFS_CYCLE_SEL, rv);
        check("cycle select", rv, 32'h0000_00ff);
        wr(OFS_CONTROL, 32'hffff_ffff);
        rd(OFS_CONTROL, rv);
        // The channel B CPU flag of the last row survives a write of ones.
        check("control", rv, 32'h0030_4cc9);
        check("setting outputs", {ign_a, ign_b, trace, after_a, after_b}, 5'h1f);
        rd(8'h1c, rv);
        check("unmapped", rv, 32'h0);
        $display("test access done");
        // Sticky flag, interrupt status, mask and clear.
        wr(OFS_DATA_MASK, 32'h0);
        wr(OFS_CYCLE_SEL, 32'h55);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_INT_CLEAR, 32'h7);
        wr(OFS_INT_ENABLE, 32'h7);
        check("irq idle", irq, 1'b0);
        cyc(3'h2, 2'h1, 32'h0, 1'b1, 1'b0);
        check("irq set", irq, 1'b1);
        wr(OFS_CONTROL, 32'h0000_4000);
        rd(OFS_CONTROL, rv);
        check("flag kept", rv, 32'h0000_4000);
        wr(OFS_CONTROL, 32'h0);
        rd(OFS_CONTROL, rv);
        check("flag cleared", rv, 32'h0);
        wr(OFS_INT_STATUS, 32'h0);
        rd(OFS_INT_STATUS, rv);
        check("status", rv, 32'h5);
        wr(OFS_INT_ENABLE, 32'h0);
        check("irq masked", irq, 1'b0);
        wr(OFS_INT_ENABLE, 32'h7);
        wr(OFS_INT_CLEAR, 32'h7);
        rd(OFS_INT_STATUS, rv);
        check("status cleared", rv, 32'h0);
        check("irq cleared", irq, 1'b0);
        $display("test interrupt done");
        // Chained channels: B alone, A alone, A then B, B again.
        wr(OFS_CONTROL, 32'h8);
        cyc(3'h2, 2'h1, 32'h0, 1'b1, 1'b0);
        check("chain b alone", 32'(nb), 32'h0);
        cyc(3'h6, 2'h1, 32'h0, 1'b1, 1'b1);
        check("chain a alone", 32'(nb), 32'h0);
        cyc(3'h2, 2'h1, 32'h0, 1'b1, 1'b0);
        check("chain a then b", 32'(nb), 32'h1);
        cyc(3'h2, 2'h1, 32'h0, 1'b1, 1'b0);
        check("chain disarmed", 32'(nb), 32'h0);
        // Independent channels: channel A alone breaks.
        wr(OFS_CONTROL, 32'h0);
        cyc(3'h6, 2'h1, 32'h0, 1'b1, 1'b1);
        check("independent a", 32'(nb), 32'h1);
        $display("test chain done");
        // Count mode: decrement until the count reaches one, then break.
        wr(OFS_CONTROL, 32'h1);
        cyc(3'h2, 2'h1, 32'h0, 1'b1, 1'b0);
        check("count step", {nb[3:0], nd[3:0]}, 8'h01);
        @(posedge clk) count_is_one <= 1;
        cyc(3'h2, 2'h1, 32'h0, 1'b1, 1'b0);
        check("count break", 32'(nb), 32'h1);
        $display("test count done");
        // A second reset in mid-run restores reset values.
        @(posedge clk) rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        rd(OFS_CONTROL, rv);
        check("second reset", rv, RST_WORD);
        rd(OFS_DATA_VALUE, rv);
        check("second reset data", rv, RST_WORD);
        $display("test second reset done");
        results();
    end
endmodule
